// ### bench/sccr_bank_assertions.sv
// Port-level assertions for the register bank
`timescale 1ns/1ns
`include "sccr_regs.svh"
module sccr_bank_assertions (
	input wire logic       clk_sys, reset_n, cmd_valid, cmd_write, rsp_valid, digital_reset,
	input wire logic       raw_data_select, offset_monitor_enable, init_done_lock,
	input wire logic [5:0] cmd_addr,
	input wire logic [7:0] cmd_wdata, rsp_rdata,
	input wire logic [1:0] oc_phase,
	input wire logic [2:0] arm_mode
);
	logic ca, cw, k3, lk;
	assign ca = cmd_valid && cmd_addr == `SCCR_CTL_ADDR;
	assign cw = ca && cmd_write;
	assign k3 = cw && cmd_wdata[7:6] == `SCCR_KEY_THIRD;
	assign lk = init_done_lock && !digital_reset;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	AST_RSP_PULSE: assert property (cmd_valid |=> rsp_valid)
		else $error("no response");
	AST_KEY_HIDDEN: assert property (ca |=> !rsp_rdata[7:6])
		else $error("key bits shown");
	AST_KEY_RESET: assert property ((cw && cmd_wdata[7:6] == `SCCR_KEY_FIRST) ##1
		(cw && cmd_wdata[7:6] == `SCCR_KEY_SECOND) ##1 k3 |=> digital_reset)
		else $error("no key reset");
	AST_RESET_CAUSE: assert property (digital_reset |-> $past(k3))
		else $error("stray reset");
	AST_LOCK_NORMAL: assert property (init_done_lock |-> oc_phase == `SCCR_PHASE_NORMAL)
		else $error("phase not normal");
	AST_MON_FORCED: assert property (!raw_data_select |-> offset_monitor_enable)
		else $error("monitor off");
	AST_LOCK_STICKY: assert property (lk && !$past(digital_reset) |=> init_done_lock)
		else $error("lock lost");
	AST_ARM_FROZEN: assert property (lk && !$past(digital_reset) |=> $stable(arm_mode))
		else $error("arm mode changed");
	AST_COV_KEY: cover property (digital_reset);
	AST_COV_LOCKED_WR: cover property (init_done_lock && cw);
	AST_COV_CTL_RD: cover property (ca && !cmd_write);
endmodule : sccr_bank_assertions
bind sccr_bank sccr_bank_assertions u_chk (.clk_sys, .reset_n, .cmd_valid, .cmd_write,
	.rsp_valid, .digital_reset, .raw_data_select, .offset_monitor_enable, .init_done_lock,
	.cmd_addr, .cmd_wdata, .rsp_rdata, .oc_phase, .arm_mode);

// ### bench/sccr_host.sv
// Host model driving register commands
`timescale 1ns/1ns
`include "sccr_regs.svh"
module sccr_host (
	input  wire logic  clk_sys,
	output logic       cmd_valid, cmd_write,
	output logic [5:0] cmd_addr,
	output logic [7:0] cmd_wdata
);
	initial {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = 16'h0000;
	task cmd(input logic w, input logic [5:0] a, input logic [7:0] d);
		{cmd_valid, cmd_write, cmd_addr} = {1'h1, w, a};
		cmd_wdata = d & (a == `SCCR_CTL_ADDR ? 8'hF8 : 8'hBF);
		@(posedge clk_sys) #1;
	endtask : cmd
	// Released lines toggle so stale data never looks valid
	task idle();
		{cmd_valid, cmd_addr, cmd_wdata} = {1'h0, ~cmd_addr, ~cmd_wdata};
		@(posedge clk_sys) #1;
	endtask : idle
endmodule : sccr_host

// ### bench/tb.sv
// Directed and random bench for the register bank
`timescale 1ns/1ns
module tb;
	logic        clk_sys, reset_n, deflect_req, cmd_valid, cmd_write, rsp_valid, rsp_hit, dr;
	logic [5:0]  cmd_addr;
	logic [7:0]  cmd_wdata, rsp_rdata, ctl_m, cfg_m;
	logic [10:0] x;
	wire  [10:0] o;
	wire  [2:0]  pm;
	int          n_errors, n_checks, seed, key_m, i, r;
	logic [14:0] tab [20] = '{15'h0A00, 15'h0B00, 15'h4A08, 15'h4A18, 15'h4A28, 15'h4A38,
		15'h4A28, 15'h4A30, 15'h4A00, 15'h4AC0, 15'h0A00, 15'h4A40, 15'h4B90, 15'h4B23,
		15'h4B00, 15'h4A08, 15'h4A00, 15'h4AC0, 15'h4A40, 15'h0B00};
	sccr_host u_host (.clk_sys, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata);
	sccr_bank DUT (.clk_sys, .reset_n, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata,
		.deflect_req, .rsp_valid, .rsp_hit, .rsp_rdata, .digital_reset(dr), .oc_phase(o[10:9]),
		.offset_monitor_enable(o[8]), .init_done_lock(o[7]), .deflection_check_enable(o[6]),
		.arm_mode(o[5:3]), .raw_data_select(o[2]), .unsigned_format(o[1]),
		.wcrc_enable(o[0]), .arm_out_enable(pm[2]), .arm_active_low(pm[1]), .arm_pcm(pm[0]));
	function automatic logic [2:0] arm_pins(input logic [2:0] m);
		arm_pins = {m != 3'h0, m[0] && m != 3'h1, m == 3'h1};
	endfunction : arm_pins
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task op(input logic w, input logic [5:0] a, input logic [7:0] d);
		logic [9:0] e;
		e = {1'h1, a == 6'h0A || a == 6'h0B, a == 6'h0A ? {2'h0, ctl_m[5:0]} : a == 6'h0B ? cfg_m : 8'h00};
		u_host.cmd(w, a, d);
		d = cmd_wdata;
		key_m = !(w && a == 6'h0A) ? 0 : d[7:6] == 2'h0 ? 1 : key_m == 1 && d[7:6] == 2'h3 ? 2
			: key_m == 2 && d[7:6] == 2'h1 ? 3 : 0;
		if (w && !cfg_m[5] && a == 6'h0A)
			ctl_m = {2'h0, ctl_m[3] && d[3] ? d[5:4] : ctl_m[5:4], d[3:0]};
		if (w && !cfg_m[5] && a == 6'h0B)
			cfg_m = d;
		chk("response", e, {rsp_valid, rsp_hit, rsp_rdata});
		chk("key reset", key_m == 3, dr);
		if (key_m == 3) begin
			{ctl_m, cfg_m, key_m} = 48'h0;
			u_host.idle();
		end
	endtask : op
	// Outputs lag storage by a cycle, so sample after one idle edge
	task chkout();
		r = $random(seed);
		deflect_req = r[0];
		x = {cfg_m[5] ? 2'h3 : ctl_m[5:4], cfg_m[3] | ~cfg_m[7], cfg_m[5], r[0] & ~cfg_m[5],
			cfg_m[2:0], cfg_m[7], cfg_m[4], cfg_m[5]};
		u_host.idle();
		chk("outputs", x, o);
		chk("arm pins", arm_pins(cfg_m[2:0]), pm);
	endtask : chkout
	task end_sim();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		end_sim();
	end
	initial begin
		{reset_n, deflect_req, ctl_m, cfg_m} = 18'h00000;
		seed = 32'h426F;
		repeat (10) @(posedge clk_sys);
		#1 reset_n = 1'h1;
		foreach (tab[j]) begin
			op(tab[j][14], tab[j][13:8], tab[j][7:0]);
			chkout();
		end
		for (i = 0; i < 400; i++) begin
			r = $random(seed);
			if (r[31:29] == 3'h0)
				for (int k = 0; k < 3; k++) op(1'h1, 6'h0A, 8'(24'h40C000 >> (8 * k)));
			op(r[0], r[1] ? {5'h05, r[2]} : r[8:3], r[23:16]);
			if (r[5:4] == 2'h0) chkout();
		end
		end_sim();
	end
endmodule : tb

// ### rtl/sccr_bank.sv
// Control and configuration register pair with reset key and init lock
`timescale 1ns/1ns
`include "sccr_regs.svh"
module sccr_bank
	import sccr_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	input  wire logic                    cmd_valid,
	input  wire logic                    cmd_write,
	input  wire logic [`SCCR_ADDR_W-1:0] cmd_addr,
	input  wire logic [7:0]              cmd_wdata,
	input  wire logic                    deflect_req,
	output logic                         rsp_valid,
	output logic [7:0]                   rsp_rdata,
	output logic                         rsp_hit,
	output logic                         digital_reset,
	output logic [1:0]                   oc_phase,
	output logic                         raw_data_select,
	output logic                         unsigned_format,
	output logic                         offset_monitor_enable,
	output logic                         init_done_lock,
	output logic                         wcrc_enable,
	output logic                         deflection_check_enable,
	output logic [2:0]                   arm_mode,
	output logic                         arm_out_enable,
	output logic                         arm_active_low,
	output logic                         arm_pcm
);

	logic [5:0]  ctl_q, ctl_d;
	logic [7:0]  cfg_q, cfg_d;
	sccr_key_t   key_q, key_d;
	logic        rst_pulse_q, rst_pulse_d;
	logic        rsp_valid_q, rsp_valid_d;
	logic [7:0]  rsp_q, rsp_d;
	logic        hit_q, hit_d;
	logic [1:0]  phase_q, phase_d;
	logic [2:0]  arm_q, arm_d;
	logic [5:0]  flags_q, flags_d;
	logic [2:0]  pin_q, pin_d;
	logic        lock;
	logic        ctl_wr, cfg_wr;
	logic [1:0]  key_in;

	// Decode of one register address
	function automatic logic addr_is(input logic [`SCCR_ADDR_W-1:0] a,
		input logic [`SCCR_ADDR_W-1:0] r);
		addr_is = (a == r);
	endfunction : addr_is

	assign lock   = cfg_q[`SCCR_LOCK];
	assign ctl_wr = cmd_valid & cmd_write & addr_is(cmd_addr, `SCCR_CTL_ADDR);
	assign cfg_wr = cmd_valid & cmd_write & addr_is(cmd_addr, `SCCR_CFG_ADDR);
	assign key_in = cmd_wdata[`SCCR_KEY_HI:`SCCR_KEY_LO];

	// Register contents
	always_comb begin
		ctl_d = ctl_q;
		cfg_d = cfg_q;
		if (ctl_wr && !lock) begin
			if (cmd_wdata[`SCCR_OVR_EN] && ctl_q[`SCCR_OVR_EN]) begin
				ctl_d[`SCCR_PHASE_HI:`SCCR_PHASE_LO] =
					cmd_wdata[`SCCR_PHASE_HI:`SCCR_PHASE_LO];
			end
			ctl_d[`SCCR_OVR_EN] = cmd_wdata[`SCCR_OVR_EN];
			ctl_d[2:0] = cmd_wdata[2:0];
		end
		if (cfg_wr && !lock) begin
			cfg_d = cmd_wdata;
		end
	end

	// Reset key tracker and responses
	always_comb begin
		key_d       = key_q;
		rst_pulse_d = 1'b0;
		rsp_valid_d = 1'b0;
		rsp_d       = rsp_q;
		hit_d       = hit_q;
		if (cmd_valid) begin
			key_d = SCCR_KEY_IDLE;
			if (ctl_wr) begin
				case (key_q)
					SCCR_KEY_IDLE: begin
						if (key_in == `SCCR_KEY_FIRST) key_d = SCCR_KEY_GOT1;
					end
					SCCR_KEY_GOT1: begin
						if (key_in == `SCCR_KEY_SECOND) key_d = SCCR_KEY_GOT2;
						else if (key_in == `SCCR_KEY_FIRST) key_d = SCCR_KEY_GOT1;
					end
					SCCR_KEY_GOT2: begin
						if (key_in == `SCCR_KEY_THIRD) rst_pulse_d = 1'b1;
						else if (key_in == `SCCR_KEY_FIRST) key_d = SCCR_KEY_GOT1;
					end
					default: key_d = SCCR_KEY_IDLE;
				endcase
			end
			rsp_valid_d = 1'b1;
			hit_d       = 1'b1;
			if (addr_is(cmd_addr, `SCCR_CTL_ADDR)) begin
				rsp_d = {2'h0, ctl_q};
			end else if (addr_is(cmd_addr, `SCCR_CFG_ADDR)) begin
				rsp_d = cfg_q;
			end else begin
				rsp_d = `SCCR_RST_VAL;
				hit_d = 1'b0;
			end
		end
	end

	// Derived controls
	always_comb begin
		phase_d = ctl_q[`SCCR_PHASE_HI:`SCCR_PHASE_LO];
		if (lock) phase_d = `SCCR_PHASE_NORMAL;
		arm_d = cfg_q[`SCCR_ARM_HI:`SCCR_ARM_LO];
		pin_d[2] = |cfg_q[`SCCR_ARM_HI:`SCCR_ARM_LO];
		pin_d[1] = cfg_q[`SCCR_ARM_LO] & (cfg_q[`SCCR_ARM_HI] | cfg_q[`SCCR_ARM_LO+1]);
		pin_d[0] = (cfg_q[`SCCR_ARM_HI:`SCCR_ARM_LO] == `SCCR_ARM_PCM);
		flags_d[0] = cfg_q[`SCCR_RAW_SEL];
		flags_d[1] = cfg_q[`SCCR_UNSIGNED];
		flags_d[2] = cfg_q[`SCCR_MON_EN] | ~cfg_q[`SCCR_RAW_SEL];
		flags_d[3] = lock;
		flags_d[4] = lock;
		flags_d[5] = deflect_req & ~lock;
	end

	always_ff @(posedge clk_sys) begin
		// All state but the reset pulse cleared on either reset; flags load SCCR_FLAGS_RST
		if (!reset_n || rst_pulse_q) begin
			ctl_q       <= 6'h00;
			cfg_q       <= `SCCR_RST_VAL;
			key_q       <= SCCR_KEY_IDLE;
			rsp_valid_q <= 1'b0;
			rsp_q       <= `SCCR_RST_VAL;
			hit_q       <= 1'b0;
			phase_q     <= 2'h0;
			arm_q       <= 3'h0;
			pin_q       <= 3'h0;
			// Monitor forced on: cleared config selects cancelled data
			flags_q     <= `SCCR_FLAGS_RST;
		end else begin
			ctl_q       <= ctl_d;
			cfg_q       <= cfg_d;
			key_q       <= key_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_q       <= rsp_d;
			hit_q       <= hit_d;
			phase_q     <= phase_d;
			arm_q       <= arm_d;
			pin_q       <= pin_d;
			flags_q     <= flags_d;
		end
	end

	// Pulse survives its own reset so the outside sees it
	always_ff @(posedge clk_sys) begin
		if (!reset_n) rst_pulse_q <= 1'b0;
		else          rst_pulse_q <= rst_pulse_d;
	end

	assign rsp_valid               = rsp_valid_q;
	assign rsp_rdata               = rsp_q;
	assign rsp_hit                 = hit_q;
	assign digital_reset           = rst_pulse_q;
	assign oc_phase                = phase_q;
	assign raw_data_select         = flags_q[0];
	assign unsigned_format         = flags_q[1];
	assign offset_monitor_enable   = flags_q[2];
	assign init_done_lock          = flags_q[3];
	assign wcrc_enable             = flags_q[4];
	assign deflection_check_enable = flags_q[5];
	assign arm_mode                = arm_q;
	assign arm_out_enable          = pin_q[2];
	assign arm_active_low          = pin_q[1];
	assign arm_pcm                 = pin_q[0];

endmodule : sccr_bank

// ### rtl/sccr_pkg.sv
// Types for the control and configuration register bank
package sccr_pkg;
	typedef enum logic [2:0] {
		SCCR_KEY_IDLE = 3'h1,
		SCCR_KEY_GOT1 = 3'h2,
		SCCR_KEY_GOT2 = 3'h4
	} sccr_key_t;
	typedef enum logic [1:0] {
		SCCR_PH_START1 = 2'h0,
		SCCR_PH_START2 = 2'h1,
		SCCR_PH_START3 = 2'h2,
		SCCR_PH_NORMAL = 2'h3
	} sccr_phase_t;
endpackage : sccr_pkg

// ### rtl/sccr_regs.svh
// Register map and field constants for the control and configuration registers
`ifndef SCCR_REGS_SVH
`define SCCR_REGS_SVH
`define SCCR_ADDR_W        6
`define SCCR_CTL_ADDR      6'h0A
`define SCCR_CFG_ADDR      6'h0B
`define SCCR_RST_VAL       8'h00
`define SCCR_KEY_HI        7
`define SCCR_KEY_LO        6
`define SCCR_PHASE_HI      5
`define SCCR_PHASE_LO      4
`define SCCR_OVR_EN        3
`define SCCR_CTL_LOCKMASK  8'h3F
`define SCCR_KEY_FIRST     2'h0
`define SCCR_KEY_SECOND    2'h3
`define SCCR_KEY_THIRD     2'h1
`define SCCR_RAW_SEL       7
`define SCCR_LOCK          5
`define SCCR_UNSIGNED      4
`define SCCR_MON_EN        3
`define SCCR_ARM_HI        2
`define SCCR_ARM_LO        0
`define SCCR_PHASE_NORMAL  2'h3
`define SCCR_ARM_PCM       3'h1
`define SCCR_FLAGS_RST     6'h04
`endif
